/* File: src/spmc_top.v */
// System power mode control: regulator, deep-off, sub-modes, RAM power
`timescale 1ns/100ps
`include "spmc_consts.vh"

module spmc_top #(
    parameter RAM_SECTIONS = 6
) (
    input  wire                    sys_clk,
    input  wire                    rst,
    input  wire                    por_rst,
    input  wire                    retain_clr,
    input  wire [7:0]              avs_address,
    input  wire                    avs_read,
    input  wire                    avs_write,
    input  wire [31:0]             avs_writedata,
    input  wire [3:0]              avs_byteenable,
    output wire [31:0]             avs_readdata,
    output wire                    avs_waitrequest,
    input  wire                    pin_detect,
    input  wire                    debug_mode,
    input  wire                    load_high,
    input  wire                    cpu_idle,
    input  wire                    periph_idle,
    input  wire [3:0]              reset_src,
    output wire                    switching_active,
    output wire                    linear_active,
    output wire                    core_power_off,
    output wire                    periph_power_off,
    output wire                    task_abort,
    output wire                    sys_reset_req,
    output wire                    power_sources_on,
    output wire                    basic_res_forced,
    output wire                    fixed_latency_mode,
    output wire                    auto_supply_sel,
    output wire [RAM_SECTIONS-1:0] ram_power_on,
    output wire [RAM_SECTIONS-1:0] ram_retain_on
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    reg  [2:0] pin_s1_q;
    reg  [2:0] pin_s2_q;
    wire       detect_s;
    wire       debug_s;
    wire       load_s;

    // Only the second stage feeds logic
    always @(posedge sys_clk) begin
        if (rst) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {load_high, debug_mode, pin_detect};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign detect_s = pin_s2_q[0];
    assign debug_s  = pin_s2_q[1];
    assign load_s   = pin_s2_q[2];

    // ****************************************
    // Avalon slave handshake
    // ****************************************
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    wire        req;
    wire        wr_fire;
    wire [31:0] be_mask;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    assign wr_fire         = avs_write & ack_q;
    assign avs_readdata    = rdata_q;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_be
            assign be_mask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ****************************************
    // Register write decode
    // ****************************************
    wire wr_fixlat;
    wire wr_lowest_power_task;
    wire wr_deepoff;
    wire wr_swreg;
    wire wr_cause;
    wire wr_ram_ret;
    wire wr_ram_pwr;
    wire bit0_w;

    assign bit0_w     = avs_writedata[0] & avs_byteenable[0];
    assign wr_fixlat  = wr_fire & (avs_address == `SPMC_OFS_FIXLAT);
    assign wr_lowest_power_task  = wr_fire & (avs_address == `SPMC_OFS_LOWEST_POWER_TASK);
    assign wr_deepoff = wr_fire & (avs_address == `SPMC_OFS_DEEPOFF);
    assign wr_swreg   = wr_fire & (avs_address == `SPMC_OFS_SWREG_EN);
    assign wr_cause   = wr_fire & (avs_address == `SPMC_OFS_CAUSE);
    assign wr_ram_ret = wr_fire & (avs_address == `SPMC_OFS_RAM_RET);
    assign wr_ram_pwr = wr_fire & (avs_address == `SPMC_OFS_RAM_PWR);

    // ****************************************
    // Task pulses
    // ****************************************
    wire fixlat_task;
    wire lowest_power_task_task;
    wire deepoff_task;

    assign fixlat_task  = wr_fixlat & bit0_w;
    assign lowest_power_task_task  = wr_lowest_power_task & bit0_w;
    assign deepoff_task = wr_deepoff & bit0_w;

    // ****************************************
    // Regulator selection
    // ****************************************
    reg swreg_en_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            swreg_en_q <= `SPMC_RST_SWREG;
        end else if (wr_swreg && avs_byteenable[0]) begin
            swreg_en_q <= avs_writedata[0];
        end
    end

    assign switching_active = swreg_en_q & load_s;
    assign linear_active    = ~switching_active;

    // ****************************************
    // Power state machine
    // ****************************************
    localparam [2:0] ST_ON   = `SPMC_S_ON;
    localparam [2:0] ST_OFF  = `SPMC_S_OFF;
    localparam [2:0] ST_EMUL = `SPMC_S_EMUL;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg        abort_q;
    reg        wake_q;
    reg        wake_done_q;
    wire       in_on;
    wire       in_deep;

    assign in_on   = state_q[0];
    assign in_deep = state_q[1] | state_q[2];

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_ON: begin
                if (deepoff_task) begin
                    state_d = debug_s ? ST_EMUL : ST_OFF;
                end
            end
            // Both deep-off states are left only through rst
            ST_OFF: begin
                state_d = ST_OFF;
            end
            ST_EMUL: begin
                state_d = ST_EMUL;
            end
            default: begin
                state_d = ST_ON;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_q     <= ST_ON;
            abort_q     <= 1'b0;
            wake_q      <= 1'b0;
            wake_done_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            abort_q     <= in_on & ~state_d[0];
            // One wake pulse per deep-off stay
            wake_q      <= in_deep & detect_s & ~wake_done_q;
            wake_done_q <= wake_done_q | (in_deep & detect_s);
        end
    end

    assign core_power_off   = state_q[1];
    assign periph_power_off = in_deep;
    assign task_abort       = abort_q;
    assign sys_reset_req    = wake_q;

    // ****************************************
    // Sub power modes
    // ****************************************
    reg  fixlat_q;
    wire all_idle;

    always @(posedge sys_clk) begin
        if (rst) begin
            fixlat_q <= `SPMC_RST_FIXLAT;
        end else if (fixlat_task) begin
            fixlat_q <= 1'b1;
        end else if (lowest_power_task_task) begin
            fixlat_q <= 1'b0;
        end
    end

    assign all_idle           = cpu_idle & periph_idle;
    assign power_sources_on   = in_on & ~all_idle;
    assign basic_res_forced   = in_on & (~all_idle | fixlat_q);
    assign fixed_latency_mode = in_on & all_idle & fixlat_q;
    assign auto_supply_sel    = in_on & all_idle & ~fixlat_q;

    // ****************************************
    // Reset cause
    // ****************************************
    wire [`SPMC_CAUSE_W-1:0] cause_q;
    wire [`SPMC_CAUSE_W-1:0] cause_set;
    wire [`SPMC_CAUSE_W-1:0] cause_clr;

    localparam [`SPMC_CAUSE_W-1:0] CAUSE_RST = `SPMC_RST_CAUSE;

    assign cause_set = {wake_q, reset_src};
    assign cause_clr = wr_cause ?
        (avs_writedata[`SPMC_CAUSE_W-1:0] & be_mask[`SPMC_CAUSE_W-1:0]) :
        {`SPMC_CAUSE_W{1'b0}};

    // A new cause beats a write-one-to-clear in the same cycle
    genvar gc;
    generate
        for (gc = 0; gc < `SPMC_CAUSE_W; gc = gc + 1) begin : g_cause
            reg flag_q;

            always @(posedge sys_clk) begin
                if (por_rst) begin
                    flag_q <= CAUSE_RST[gc];
                end else if (cause_set[gc]) begin
                    flag_q <= 1'b1;
                end else if (cause_clr[gc]) begin
                    flag_q <= 1'b0;
                end
            end

            assign cause_q[gc] = flag_q;
        end
    endgenerate

    // ****************************************
    // RAM section power settings
    // ****************************************
    wire [RAM_SECTIONS-1:0] ram_ret_q;
    wire [RAM_SECTIONS-1:0] ram_pwr_q;
    wire [RAM_SECTIONS-1:0] ram_be;
    wire [RAM_SECTIONS-1:0] ram_wd;

    localparam [31:0] RAM_RST = `SPMC_RST_RAM;

    assign ram_be = be_mask[RAM_SECTIONS-1:0];
    assign ram_wd = avs_writedata[RAM_SECTIONS-1:0];

    // One retention and one power bit per section; rst leaves both alone
    genvar gr;
    generate
        for (gr = 0; gr < RAM_SECTIONS; gr = gr + 1) begin : g_ram
            reg ret_q;
            reg pwr_q;

            always @(posedge sys_clk) begin
                if (por_rst || retain_clr) begin
                    ret_q <= RAM_RST[gr];
                    pwr_q <= RAM_RST[gr];
                end else begin
                    if (wr_ram_ret && ram_be[gr]) begin
                        ret_q <= ram_wd[gr];
                    end
                    if (wr_ram_pwr && ram_be[gr]) begin
                        pwr_q <= ram_wd[gr];
                    end
                end
            end

            assign ram_ret_q[gr]     = ret_q;
            assign ram_pwr_q[gr]     = pwr_q;
            assign ram_power_on[gr]  = ~core_power_off & pwr_q;
            // Powered sections are retained too while the core is on
            assign ram_retain_on[gr] = core_power_off ? ret_q : (ret_q | pwr_q);
        end
    endgenerate

    // ****************************************
    // Read data
    // ****************************************
    wire [5:0] status;

    assign status = {all_idle, state_q[2], state_q[1], in_on,
                     fixlat_q, switching_active};

    always @* begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            `SPMC_OFS_SWREG_EN: rdata_d[0] = swreg_en_q;
            `SPMC_OFS_CAUSE:    rdata_d[`SPMC_CAUSE_W-1:0] = cause_q;
            `SPMC_OFS_STATUS:   rdata_d[5:0] = status;
            `SPMC_OFS_RAM_RET:  rdata_d[RAM_SECTIONS-1:0] = ram_ret_q;
            `SPMC_OFS_RAM_PWR:  rdata_d[RAM_SECTIONS-1:0] = ram_pwr_q;
            default:            rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

endmodule // spmc_top

/* File: src/spmc_consts.vh */
// Constants for the system power mode control block
`ifndef SPMC_CONSTS_VH
`define SPMC_CONSTS_VH

// ****************************************
// Register word offsets (byte address)
// ****************************************
`define SPMC_OFS_FIXLAT    8'h00
`define SPMC_OFS_LOWEST_POWER_TASK    8'h04
`define SPMC_OFS_DEEPOFF   8'h08
`define SPMC_OFS_SWREG_EN  8'h0C
`define SPMC_OFS_CAUSE     8'h10
`define SPMC_OFS_STATUS    8'h14
`define SPMC_OFS_RAM_RET   8'h18
`define SPMC_OFS_RAM_PWR   8'h1C

// ****************************************
// Reset cause bit positions
// ****************************************
`define SPMC_CAUSE_PIN     0
`define SPMC_CAUSE_WDT     1
`define SPMC_CAUSE_SOFT    2
`define SPMC_CAUSE_LOCKUP  3
`define SPMC_CAUSE_DETECT  4
`define SPMC_CAUSE_W       5

// ****************************************
// Status bit positions
// ****************************************
`define SPMC_ST_SWITCHING  0
`define SPMC_ST_FIXLAT     1
`define SPMC_ST_ON         2
`define SPMC_ST_OFF        3
`define SPMC_ST_EMUL       4
`define SPMC_ST_IDLE       5

// ****************************************
// Power states, one-hot
// ****************************************
`define SPMC_S_ON          3'h1
`define SPMC_S_OFF         3'h2
`define SPMC_S_EMUL        3'h4

// ****************************************
// Reset values
// ****************************************
`define SPMC_RST_SWREG     1'h0
`define SPMC_RST_FIXLAT    1'h0
`define SPMC_RST_CAUSE     5'h00
`define SPMC_RST_RAM       32'h0000_0000

`endif

/* File: verif/spmc_monitor.sv */
// Assertion checker for the power mode control block
`timescale 1ns/100ps
module spmc_monitor #(
    parameter RAM_SECTIONS = 6
) (
    input wire                    sys_clk,
    input wire                    rst,
    input wire                    avs_read,
    input wire                    avs_write,
    input wire                    avs_waitrequest,
    input wire                    load_high,
    input wire                    cpu_idle,
    input wire                    periph_idle,
    input wire                    switching_active,
    input wire                    core_power_off,
    input wire                    periph_power_off,
    input wire                    task_abort,
    input wire                    sys_reset_req,
    input wire                    power_sources_on,
    input wire                    basic_res_forced,
    input wire                    fixed_latency_mode,
    input wire                    auto_supply_sel,
    input wire [RAM_SECTIONS-1:0] ram_power_on
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
// ****************************************
// Sequences
// ****************************************
sequence req_rise; $rose(avs_read || avs_write); endsequence
sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
sequence off_entry; $rose(core_power_off); endsequence
// ****************************************
// Properties
// ****************************************
lin_default_a: assert property ($past(rst) |-> !switching_active)
    else $error("switching after reset");
sw_follow_a: assert property (switching_active |-> $past(load_high, 2))
    else $error("switching without load");
bus_wait_a: assert property (req_rise |-> one_wait)
    else $error("wait cycle count wrong");
off_abort_a: assert property (off_entry |-> task_abort)
    else $error("no abort on off entry");
abort_pulse_a: assert property (task_abort |=> !task_abort)
    else $error("abort longer than one cycle");
off_hold_a: assert property (off_entry |-> core_power_off [*8])
    else $error("off left without reset");
off_ram_a: assert property (core_power_off |-> periph_power_off && ram_power_on == '0)
    else $error("power kept in off");
wake_off_a: assert property (sys_reset_req |-> periph_power_off)
    else $error("wake outside off");
src_follow_a: assert property (power_sources_on == (!periph_power_off && !(cpu_idle && periph_idle)))
    else $error("power sources wrong");
fix_idle_a: assert property (fixed_latency_mode |-> cpu_idle && periph_idle && basic_res_forced)
    else $error("fixed latency misapplied");
low_idle_a: assert property (auto_supply_sel |-> cpu_idle && periph_idle && !fixed_latency_mode)
    else $error("lowest power misapplied");
low_start_a: assert property ($past(rst) |-> !fixed_latency_mode)
    else $error("fixed latency after reset");
endmodule // spmc_monitor

/* File: verif/spmc_top_tb.sv */
// Self-checking bench for the power mode control block
`timescale 1ns/100ps
`include "spmc_consts.vh"
module spmc_top_tb;
logic        sys_clk = 0, rst = 1, por_rst = 1, retain_clr = 0, avs_read = 0, avs_write = 0;
logic        pin_detect = 0, debug_mode = 0, load_high = 0, cpu_idle = 0, periph_idle = 0;
logic [7:0]  avs_address = 0;
logic [31:0] avs_writedata = 0, rd;
logic [3:0]  avs_byteenable = 4'hf, reset_src = 0;
wire  [31:0] avs_readdata;
wire         avs_waitrequest, switching_active, linear_active, core_power_off, periph_power_off;
wire         task_abort, sys_reset_req, power_sources_on, basic_res_forced;
wire         fixed_latency_mode, auto_supply_sel;
wire  [5:0]  ram_power_on, ram_retain_on;
int          failures = 0, samples_checked = 0, seed, m_ret, m_pwr, m_cause, m_fix, i, n;
spmc_top #(.RAM_SECTIONS(6)) spmc_top_inst (.*);
initial begin
    forever #2 sys_clk = ~sys_clk;
end
initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    print_verdict;
end
// ****************************************
// Tasks
// ****************************************
task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
        failures++;
        $display("unexpected %s exp %h seen %h", nm, e, s);
    end
endtask
task bus(input bit w, input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
        @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
endtask
task rdc(input [7:0] a, input logic [31:0] e, input string nm);
    bus(0, a, 0);
    chk(nm, rd, e);
endtask
task cyc(input int c);
    repeat (c) @(negedge sys_clk);
endtask
task reset(input bit por);
    @(posedge sys_clk);
    rst <= 1;
    por_rst <= por;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    por_rst <= 0;
    m_fix = 0;
    if (por) begin
        m_ret = 0;
        m_pwr = 0;
        m_cause = 0;
    end
endtask
task watch(output int hits, input bit abort);
    hits = 0;
    repeat (10) begin
        @(negedge sys_clk);
        hits += abort ? task_abort : sys_reset_req;
    end
endtask
task wake;
    @(posedge sys_clk);
    pin_detect <= 1;
    watch(n, 0);
    chk("wake", n, 1);
    @(posedge sys_clk);
    pin_detect <= 0;
endtask
task print_verdict;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask
// ****************************************
// Main sequence
// ****************************************
initial begin
    seed = 32'hc1d5_1652;
    reset(1);
    @(posedge sys_clk);
    load_high <= 1;
    cyc(4);
    chk("linear", linear_active, 1'h1);
    rdc(`SPMC_OFS_STATUS, 32'h0000_0004, "status");
    rdc(8'h40, 32'h0000_0000, "unmapped");
    bus(1, `SPMC_OFS_SWREG_EN, 32'h0000_0001);
    for (i = 0; i < 12; i++) begin
        @(posedge sys_clk);
        load_high <= $random(seed);
        cpu_idle <= $random(seed);
        periph_idle <= $random(seed);
        cyc(3);
        chk("switching", switching_active, load_high);
        chk("sources", power_sources_on, !(cpu_idle && periph_idle));
    end
    @(posedge sys_clk);
    cpu_idle <= 1;
    periph_idle <= 1;
    for (i = 0; i < 5; i++) begin
        bus(1, i[0] ? `SPMC_OFS_LOWEST_POWER_TASK : `SPMC_OFS_FIXLAT, 32'h0000_0001);
        m_fix = !i[0];
        cyc(2);
        chk("fixlat", fixed_latency_mode, m_fix);
        chk("auto", auto_supply_sel, !m_fix);
        chk("forced", basic_res_forced, m_fix);
    end
    @(posedge sys_clk);
    avs_byteenable <= 4'he;
    bus(1, `SPMC_OFS_LOWEST_POWER_TASK, 32'h0000_0001);
    avs_byteenable <= 4'hf;
    bus(1, `SPMC_OFS_LOWEST_POWER_TASK, 32'h0000_0000);
    cyc(2);
    chk("fixlat_keep", fixed_latency_mode, m_fix);
    m_ret = $random(seed) & 63;
    m_pwr = $random(seed) & 63;
    bus(1, `SPMC_OFS_RAM_RET, m_ret);
    bus(1, `SPMC_OFS_RAM_PWR, m_pwr);
    cyc(1);
    chk("rampwr", ram_power_on, m_pwr);
    chk("ramret", ram_retain_on, m_ret | m_pwr);
    for (i = 0; i < 4; i++) begin
        @(posedge sys_clk);
        reset_src <= 4'h1 << i;
        @(posedge sys_clk);
        reset_src <= 0;
        m_cause |= 1 << i;
    end
    rdc(`SPMC_OFS_CAUSE, m_cause, "cause");
    bus(1, `SPMC_OFS_CAUSE, 32'h0000_0005);
    m_cause &= ~5;
    rdc(`SPMC_OFS_CAUSE, m_cause, "cause");
    reset(0);
    cyc(2);
    chk("fixlat", fixed_latency_mode, 1'h0);
    rdc(`SPMC_OFS_RAM_PWR, m_pwr, "rampwr");
    @(posedge sys_clk);
    debug_mode <= 1;
    cyc(3);
    // No DMA traffic in flight; only status reads follow the request
    bus(1, `SPMC_OFS_DEEPOFF, 32'h0000_0001);
    watch(n, 1);
    chk("emul_abort", n, 1);
    chk("emul_periph", periph_power_off, 1'h1);
    chk("emul_core", core_power_off, 1'h0);
    rdc(`SPMC_OFS_STATUS, 32'h0000_0030, "status");
    wake;
    m_cause |= 16;
    @(posedge sys_clk);
    debug_mode <= 0;
    reset(0);
    cyc(3);
    bus(1, `SPMC_OFS_DEEPOFF, 32'h0000_0001);
    watch(n, 1);
    chk("abort", n, 1);
    chk("core_off", core_power_off, 1'h1);
    chk("rampwr", ram_power_on, 6'h00);
    chk("ramret", ram_retain_on, m_ret);
    watch(n, 0);
    chk("no_wake", n, 0);
    rdc(`SPMC_OFS_STATUS, 32'h0000_0028, "status");
    wake;
    reset(0);
    cyc(2);
    rdc(`SPMC_OFS_CAUSE, m_cause, "cause");
    rdc(`SPMC_OFS_STATUS, 32'h0000_0024, "status");
    @(posedge sys_clk);
    retain_clr <= 1;
    @(posedge sys_clk);
    retain_clr <= 0;
    rdc(`SPMC_OFS_RAM_RET, 32'h0000_0000, "ramret");
    print_verdict;
end
endmodule // spmc_top_tb
bind spmc_top spmc_monitor #(.RAM_SECTIONS(RAM_SECTIONS)) spmc_monitor_inst (.*);
